// ==== inc/aphdc_pkg.sv ====
// Constants and helpers for the ATM PHY diagnostic and HEC control block
package aphdc_pkg;
	// Register offsets and reset values
	localparam logic [7:0] REG_DIAG_OFS = 8'h02;
	localparam logic [7:0] REG_HECC_OFS = 8'h03;
	localparam logic [7:0] DIAG_RST     = 8'h00;
	localparam logic [3:0] HECC_RST     = 4'h0;
	// Diagnostic control fields
	localparam int DIAG_FORCE_B = 7;
	localparam int DIAG_EARLY_B = 6;
	localparam int DIAG_MPHY_B  = 5;
	localparam int DIAG_FLUSH_B = 4;
	localparam int DIAG_PERR_B  = 3;
	localparam int DIAG_HERR_B  = 2;
	localparam int DIAG_LOOP_LSB = 0;
	// Indicator and header check fields
	localparam int HECC_CHKDIS_B = 6;
	localparam int HECC_INSDIS_B = 5;
	localparam int HECC_REFW_LSB = 3;
	localparam int HECC_TXEMP_B  = 2;
	localparam int HECC_TRANSMIT_ACTIVITY_INDICATOR_B  = 1;
	localparam int HECC_RECEIVE_ACTIVITY_INDICATOR_B  = 0;
	// Loopback codes
	localparam logic [1:0] LOOP_NORMAL = 2'h0;
	localparam logic [1:0] LOOP_PHY    = 2'h1;
	localparam logic [1:0] LOOP_LINE   = 2'h2;
	// Cell byte positions
	localparam logic [5:0] POS_HEC   = 6'h04;
	localparam logic [5:0] POS_EARLY = 6'h30;
	localparam logic [5:0] POS_LAST  = 6'h34;
	// Header check polynomial and coset
	localparam logic [7:0] HEC_POLY  = 8'h07;
	localparam logic [7:0] HEC_COSET = 8'h55;
	// Indicator stretch length in cycles
	localparam logic [7:0] LED_HOLD_CYC = 8'hff;

	function automatic logic [5:0] aphdc_pos_nxt(input logic [5:0] pos);
		return (pos == POS_LAST) ? 6'h00 : pos + 6'h01;
	endfunction

	function automatic logic [7:0] aphdc_led_nxt(input logic [7:0] cnt,
		input logic ev);
		if (ev)
			return LED_HOLD_CYC;
		return (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
	endfunction
endpackage

// ==== rtl/aphdc_hec.sv ====
// Combinational header check byte update
`timescale 1ns/1ps
`default_nettype none
module aphdc_hec
	import aphdc_pkg::*;
(
	input  wire logic [7:0] crc_in,
	input  wire logic [7:0] byte_in,
	output logic      [7:0] crc_out
);
	always_comb begin
		logic [7:0] c;
		c = crc_in ^ byte_in;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ HEC_POLY) : (c << 1);
		end
		crc_out = c;
	end
endmodule // aphdc_hec
`default_nettype wire

// ==== rtl/aphdc_skid.sv ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module aphdc_skid #(
	parameter int W = 9
) (
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic      [W-1:0] out_data,
	input  wire logic         out_ready
);
	logic [W-1:0] mem_ff [2];
	logic         wp_ff;
	logic         rp_ff;
	logic [1:0]   cnt_ff;
	logic         push;
	logic         pop;

	assign in_ready  = (cnt_ff != 2'h2);
	assign out_valid = (cnt_ff != 2'h0);
	assign out_data  = mem_ff[rp_ff];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge sys_clk) begin
		if (push)
			mem_ff[wp_ff] <= in_data;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wp_ff  <= 1'b0;
			rp_ff  <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			wp_ff  <= wp_ff ^ push;
			rp_ff  <= rp_ff ^ pop;
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // aphdc_skid
`default_nettype wire

// ==== rtl/aphdc_top.sv ====
// Diagnostic and header check control of the ATM PHY convergence layer
`timescale 1ns/1ps
`default_nettype none
// How it works
// - The force bit holds transmit cell-available low.
// - Standard mode drops receive cell-available after the last byte.
// - Early mode drops it after payload byte 44 if no cell follows.
// - Receive outputs float only in multi-PHY mode with enable high.
// - The flush bit empties the receive FIFO and then clears itself.
// - Payload error insertion flips bit 0 of the last payload byte.
// - Header error insertion flips bit 0 of the fifth header byte.
// - A two-bit field picks normal, PHY or line loopback reception.
// - Received header bytes are checked unless checking is disabled.
// - The fifth transmit byte is replaced by the computed HEC.
// - The timing marker lasts 1, 2, 4 or 8 cycles by its field.
// - A status bit reads 1 while the transmit buffer is empty.
// - The transmit activity bit reads 0 after a cell is sent.
// - The receive activity bit reads 0 after a cell is received.
module aphdc_top
	import aphdc_pkg::*;
#(
	parameter int RX_AW = 8
) (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       ub_ale,
	input  wire logic       ub_cs_n,
	input  wire logic       ub_rd_n,
	input  wire logic       ub_wr_n,
	input  wire logic [7:0] ub_ad_in,
	output logic      [7:0] ub_ad_out,
	output logic            ub_ad_oe_n,
	input  wire logic       utx_enb_n,
	input  wire logic [7:0] utx_data,
	input  wire logic       utx_soc,
	output logic            utx_clav,
	input  wire logic       urx_enb_n,
	output logic      [7:0] urx_data,
	output logic            urx_parity,
	output logic            urx_soc,
	output logic            urx_oe_n,
	output logic            urx_clav,
	output logic      [7:0] line_tx_data,
	output logic            line_tx_soc,
	output logic            line_tx_valid,
	input  wire logic       line_tx_ready,
	input  wire logic [7:0] line_rx_data,
	input  wire logic       line_rx_soc,
	input  wire logic       line_rx_valid,
	input  wire logic       line_rx_mark,
	output logic            receive_timing_marker,
	output logic            rx_hec_error,
	output logic            transmit_activity_indicator_n,
	output logic            receive_activity_indicator_n
);
	localparam logic [RX_AW:0] RX_FULL = {1'b1, {RX_AW{1'b0}}};

	logic [11:0]      ub_s1_ff;
	logic [11:0]      ub_s2_ff;
	logic [11:0]      ub_s3_ff;
	logic [7:0]       ub_addr_ff;
	logic [7:0]       ub_rdata_ff;
	logic             wr_evt;
	logic [7:0]       diag_ff;
	logic [3:0]       hecc_ff;
	logic [1:0]       loop_sel;
	logic             phy_loop;
	logic             line_loop;
	logic             sk_in_ready;
	logic             sk_valid;
	logic [8:0]       sk_data;
	logic             sk_ready;
	logic [5:0]       tx_pos_ff;
	logic [5:0]       tx_cur;
	logic [7:0]       tx_crc_ff;
	logic [7:0]       tx_crc_nxt;
	logic [7:0]       tx_byte;
	logic             tx_take;
	logic             out_free;
	logic             tx_acc;
	logic [7:0]       ltx_data_ff;
	logic             ltx_soc_ff;
	logic             ltx_valid_ff;
	logic             rx_valid;
	logic [7:0]       rx_byte;
	logic             rx_soc;
	logic [5:0]       rx_pos_ff;
	logic [5:0]       rx_cur;
	logic [7:0]       rx_crc_ff;
	logic [7:0]       rx_crc_nxt;
	logic             rx_drop_ff;
	logic             rx_wr;
	logic             rx_rd;
	logic [7:0]       rx_mem [2**RX_AW];
	logic [RX_AW-1:0] rx_wp_ff;
	logic [RX_AW-1:0] rx_rp_ff;
	logic [RX_AW:0]   rx_fill_ff;
	logic [3:0]       rx_cells_ff;
	logic [5:0]       rd_pos_ff;
	logic [7:0]       urx_data_ff;
	logic             urx_soc_ff;
	logic             hec_err_ff;
	logic [3:0]       mark_cnt_ff;
	logic [7:0]       tx_led_ff;
	logic [7:0]       rx_led_ff;

	////////////////////////////////////////////////////////////////////////
	// Utility bus pins cross in through two flops; third one finds edges
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ub_s1_ff <= 12'h0e00;
			ub_s2_ff <= 12'h0e00;
			ub_s3_ff <= 12'h0e00;
		end else begin
			ub_s1_ff <= {ub_ale, ub_cs_n, ub_rd_n, ub_wr_n, ub_ad_in};
			ub_s2_ff <= ub_s1_ff;
			ub_s3_ff <= ub_s2_ff;
		end
	end

	// Write lands on the rising edge of the write strobe
	assign wr_evt = ub_s2_ff[8] & ~ub_s3_ff[8] & ~ub_s2_ff[10];

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			ub_addr_ff <= 8'h00;
		else if (ub_s3_ff[11] & ~ub_s2_ff[11])
			ub_addr_ff <= ub_s2_ff[7:0];
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			ub_rdata_ff <= 8'h00;
		else if (ub_addr_ff == REG_DIAG_OFS)
			ub_rdata_ff <= diag_ff;
		else if (ub_addr_ff == REG_HECC_OFS)
			ub_rdata_ff <= {1'b0, hecc_ff, ~(sk_valid | ltx_valid_ff),
				transmit_activity_indicator_n,
				receive_activity_indicator_n};
		else
			ub_rdata_ff <= 8'h00;
	end

	assign ub_ad_out  = ub_rdata_ff;
	assign ub_ad_oe_n = ub_s2_ff[10] | ub_s2_ff[9];

	////////////////////////////////////////////////////////////////////////
	// Control registers; a fresh flush write wins over the self clear
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			diag_ff <= DIAG_RST;
		else if (wr_evt && ub_addr_ff == REG_DIAG_OFS)
			diag_ff <= ub_s2_ff[7:0];
		else if (diag_ff[DIAG_FLUSH_B])
			diag_ff[DIAG_FLUSH_B] <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			hecc_ff <= HECC_RST;
		else if (wr_evt && ub_addr_ff == REG_HECC_OFS)
			hecc_ff <= ub_s2_ff[6:3];
	end

	assign loop_sel  = diag_ff[DIAG_LOOP_LSB +: 2];
	assign phy_loop  = (loop_sel == LOOP_PHY);
	assign line_loop = loop_sel[1];

	////////////////////////////////////////////////////////////////////////
	// Transmit path; buffer back-pressure reaches the cell-available pin
	// Forced deassert
	assign utx_clav = ~diag_ff[DIAG_FORCE_B] & sk_in_ready;

	aphdc_skid #(.W(9)) u_txbuf (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.in_valid  (~utx_enb_n),
		.in_data   ({utx_soc, utx_data}),
		.in_ready  (sk_in_ready),
		.out_valid (sk_valid),
		.out_data  (sk_data),
		.out_ready (sk_ready)
	);

	// In PHY loopback the local receiver takes every byte, not the line
	assign tx_take  = ltx_valid_ff & (phy_loop | line_tx_ready);
	assign out_free = ~ltx_valid_ff | tx_take;
	assign sk_ready = out_free & ~line_loop;
	assign tx_acc   = sk_valid & sk_ready;
	assign tx_cur   = sk_data[8] ? 6'h00 : tx_pos_ff;

	aphdc_hec u_txhec (
		.crc_in  ((tx_cur == 6'h00) ? 8'h00 : tx_crc_ff),
		.byte_in (sk_data[7:0]),
		.crc_out (tx_crc_nxt)
	);

	always_comb begin
		tx_byte = sk_data[7:0];
		if (tx_cur == POS_HEC) begin
			if (!hecc_ff[HECC_INSDIS_B - 3])
				tx_byte = tx_crc_ff ^ HEC_COSET;
			if (diag_ff[DIAG_HERR_B])
				tx_byte[0] = ~tx_byte[0];
		end
		if (tx_cur == POS_LAST && diag_ff[DIAG_PERR_B])
			tx_byte[0] = ~tx_byte[0];
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tx_pos_ff <= 6'h00;
			tx_crc_ff <= 8'h00;
		end else if (tx_acc) begin
			tx_pos_ff <= aphdc_pos_nxt(tx_cur);
			if (tx_cur < POS_HEC)
				tx_crc_ff <= tx_crc_nxt;
		end
	end

	// Line loopback echoes received bytes onto the line
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ltx_valid_ff <= 1'b0;
			ltx_data_ff  <= 8'h00;
			ltx_soc_ff   <= 1'b0;
		end else if (line_loop && out_free) begin
			ltx_valid_ff <= line_rx_valid;
			ltx_data_ff  <= line_rx_data;
			ltx_soc_ff   <= line_rx_soc;
		end else if (tx_acc) begin
			ltx_valid_ff <= 1'b1;
			ltx_data_ff  <= tx_byte;
			ltx_soc_ff   <= (tx_cur == 6'h00);
		end else if (tx_take) begin
			ltx_valid_ff <= 1'b0;
		end
	end

	assign line_tx_data  = ltx_data_ff;
	assign line_tx_soc   = ltx_soc_ff;
	assign line_tx_valid = ltx_valid_ff & ~phy_loop;

	////////////////////////////////////////////////////////////////////////
	// Receive path and header check
	// PHY loopback takes the local transmit stream
	assign rx_valid = phy_loop ? tx_take : line_rx_valid;
	assign rx_byte  = phy_loop ? ltx_data_ff : line_rx_data;
	assign rx_soc   = phy_loop ? ltx_soc_ff : line_rx_soc;
	assign rx_cur   = rx_soc ? 6'h00 : rx_pos_ff;

	aphdc_hec u_rxhec (
		.crc_in  ((rx_cur == 6'h00) ? 8'h00 : rx_crc_ff),
		.byte_in (rx_byte),
		.crc_out (rx_crc_nxt)
	);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rx_pos_ff  <= 6'h00;
			rx_crc_ff  <= 8'h00;
			hec_err_ff <= 1'b0;
		end else begin
			hec_err_ff <= rx_valid && rx_cur == POS_HEC &&
				!hecc_ff[HECC_CHKDIS_B - 3] &&
				rx_byte != (rx_crc_ff ^ HEC_COSET);
			if (rx_valid) begin
				rx_pos_ff <= aphdc_pos_nxt(rx_cur);
				if (rx_cur < POS_HEC)
					rx_crc_ff <= rx_crc_nxt;
			end
		end
	end

	assign rx_hec_error = hec_err_ff;

	// Bytes of a cell cut by a flush are dropped until the next start
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			rx_drop_ff <= 1'b0;
		else if (diag_ff[DIAG_FLUSH_B])
			rx_drop_ff <= 1'b1;
		else if (rx_valid && rx_soc)
			rx_drop_ff <= 1'b0;
	end

	// A full FIFO drops incoming bytes; nothing flags the overflow
	assign rx_wr = rx_valid & (rx_fill_ff != RX_FULL) &
		~diag_ff[DIAG_FLUSH_B] & (~rx_drop_ff | rx_soc);
	assign rx_rd = ~urx_enb_n & (rx_cells_ff != 4'h0) &
		~diag_ff[DIAG_FLUSH_B];

	always_ff @(posedge sys_clk) begin
		if (rx_wr)
			rx_mem[rx_wp_ff] <= rx_byte;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || diag_ff[DIAG_FLUSH_B]) begin
			rx_wp_ff    <= '0;
			rx_rp_ff    <= '0;
			rx_fill_ff  <= '0;
			rx_cells_ff <= 4'h0;
			rd_pos_ff   <= 6'h00;
		end else begin
			rx_wp_ff   <= rx_wp_ff + {{(RX_AW-1){1'b0}}, rx_wr};
			rx_rp_ff   <= rx_rp_ff + {{(RX_AW-1){1'b0}}, rx_rd};
			rx_fill_ff <= rx_fill_ff + {{RX_AW{1'b0}}, rx_wr} -
				{{RX_AW{1'b0}}, rx_rd};
			rx_cells_ff <= rx_cells_ff +
				{3'h0, rx_wr && rx_cur == POS_LAST} -
				{3'h0, rx_rd && rd_pos_ff == POS_LAST};
			if (rx_rd)
				rd_pos_ff <= aphdc_pos_nxt(rd_pos_ff);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			urx_data_ff <= 8'h00;
			urx_soc_ff  <= 1'b0;
		end else if (rx_rd) begin
			urx_data_ff <= rx_mem[rx_rp_ff];
			urx_soc_ff  <= (rd_pos_ff == 6'h00);
		end
	end

	assign urx_data   = urx_data_ff;
	assign urx_soc    = urx_soc_ff;
	assign urx_parity = ~^urx_data_ff;
	assign urx_oe_n   = diag_ff[DIAG_MPHY_B] & urx_enb_n;
	assign urx_clav = (rx_cells_ff > 4'h1) || (rx_cells_ff == 4'h1 &&
		(!diag_ff[DIAG_EARLY_B] || rd_pos_ff <= POS_EARLY));

	////////////////////////////////////////////////////////////////////////
	// Timing marker stretch and activity indicators
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			mark_cnt_ff <= 4'h0;
		else if (line_rx_mark)
			mark_cnt_ff <= 4'h1 << hecc_ff[HECC_REFW_LSB - 3 +: 2];
		else if (mark_cnt_ff != 4'h0)
			mark_cnt_ff <= mark_cnt_ff - 4'h1;
	end

	assign receive_timing_marker = (mark_cnt_ff != 4'h0);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tx_led_ff <= 8'h00;
			rx_led_ff <= 8'h00;
		end else begin
			tx_led_ff <= aphdc_led_nxt(tx_led_ff,
				tx_acc && tx_cur == POS_LAST);
			rx_led_ff <= aphdc_led_nxt(rx_led_ff,
				rx_wr && rx_cur == POS_LAST);
		end
	end

	assign transmit_activity_indicator_n = (tx_led_ff == 8'h00);
	assign receive_activity_indicator_n  = (rx_led_ff == 8'h00);

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_flush_req;
		diag_ff[DIAG_FLUSH_B] && !wr_evt;
	endsequence
	sequence s_flush_done;
		!diag_ff[DIAG_FLUSH_B] && rx_fill_ff == '0 && rx_cells_ff == 4'h0;
	endsequence
	sequence s_mark8;
		line_rx_mark && hecc_ff[HECC_REFW_LSB - 3 +: 2] == 2'h3 ##1
			!line_rx_mark [*8];
	endsequence

	a_clav_forced: assert property (
		diag_ff[DIAG_FORCE_B] |-> !utx_clav)
		else $error("tx cell available while forced off");
	a_clav_standard: assert property (
		rx_rd && rd_pos_ff == POS_EARLY && rx_cells_ff == 4'h1 &&
		!diag_ff[DIAG_EARLY_B] && !rx_wr && !wr_evt |=> urx_clav)
		else $error("standard cell available dropped early");
	a_clav_early: assert property (
		rx_rd && rd_pos_ff == POS_EARLY && rx_cells_ff == 4'h1 &&
		diag_ff[DIAG_EARLY_B] && !rx_wr && !wr_evt |=> !urx_clav)
		else $error("early cell available not dropped");
	a_rx_float: assert property (
		urx_oe_n == (diag_ff[DIAG_MPHY_B] && urx_enb_n))
		else $error("receive output enable wrong");
	a_flush_clear: assert property (
		s_flush_req |=> s_flush_done)
		else $error("flush did not empty or clear");
	a_payload_flip: assert property (
		tx_acc && tx_cur == POS_LAST && diag_ff[DIAG_PERR_B] |=>
		line_tx_data[0] != $past(sk_data[0]))
		else $error("payload bit not flipped");
	a_hec_flip: assert property (
		tx_acc && tx_cur == POS_HEC && diag_ff[DIAG_HERR_B] &&
		hecc_ff[HECC_INSDIS_B - 3] |=>
		line_tx_data[0] != $past(sk_data[0]))
		else $error("header check bit not flipped");
	a_hec_insert: assert property (
		tx_acc && tx_cur == POS_HEC && !diag_ff[DIAG_HERR_B] &&
		!hecc_ff[HECC_INSDIS_B - 3] |=>
		line_tx_data == ($past(tx_crc_ff) ^ HEC_COSET))
		else $error("header check byte not inserted");
	a_hec_nocheck: assert property (
		hecc_ff[HECC_CHKDIS_B - 3] |=> !rx_hec_error)
		else $error("header checked while disabled");
	a_mark_width: assert property (
		s_mark8 |-> receive_timing_marker &&
		$past(receive_timing_marker, 7) ##1 !receive_timing_marker)
		else $error("timing marker width wrong");
	a_tx_empty: assert property (
		!sk_valid && !ltx_valid_ff |=> ub_rdata_ff[HECC_TXEMP_B] ||
		$past(ub_addr_ff) != REG_HECC_OFS)
		else $error("transmit empty status wrong");
endmodule // aphdc_top
`default_nettype wire

// ==== tb/aphdc_atm_model.sv ====
// Behavioural ATM layer device on the cell interface
`timescale 1ns/1ps
`default_nettype none
module aphdc_atm_model (
	input  wire logic       sys_clk,
	output logic            utx_enb_n,
	output logic      [7:0] utx_data,
	output logic            utx_soc,
	input  wire logic       utx_clav,
	output logic            urx_enb_n,
	input  wire logic [7:0] urx_data,
	input  wire logic       urx_soc,
	input  wire logic       urx_oe_n,
	input  wire logic       urx_clav
);
	logic [7:0] got [0:52];
	logic       cav [0:52];
	logic       soc0;
	logic       oe0;
	initial begin
		utx_enb_n = 1'b1;
		utx_data  = 8'h00;
		utx_soc   = 1'b0;
		urx_enb_n = 1'b1;
	end
	////////////////////////////////////////////////////////////
	// Room is judged after the edge, so a full buffer never loses a byte
	task automatic send_cell(input logic [7:0] base);
		int   i;
		int   w;
		logic ok;
		i = 0;
		w = 0;
		while (i < 53 && w < 3000) begin
			ok        = utx_clav;
			utx_enb_n = ~ok;
			utx_data  = base + i[7:0];
			utx_soc   = (i == 0);
			@(posedge sys_clk);
			#1;
			if (ok)
				i++;
			w++;
		end
		utx_enb_n = 1'b1;
		utx_data  = ~utx_data;
		utx_soc   = 1'b0;
	endtask
	// Reads exactly one cell and records cell-available after each byte
	task automatic read_cell();
		urx_enb_n = 1'b0;
		for (int k = 0; k < 53; k++) begin
			@(posedge sys_clk);
			#1;
			got[k] = urx_data;
			cav[k] = urx_clav;
			if (k == 0)
				soc0 = urx_soc;
			if (k == 0)
				oe0 = urx_oe_n;
			if (k == 52)
				urx_enb_n = 1'b1;
		end
	endtask
endmodule // aphdc_atm_model
`default_nettype wire

// ==== tb/aphdc_top_tb.sv ====
// Self-checking bench of the diagnostic and header check block
`timescale 1ns/1ps
`default_nettype none
module aphdc_top_tb
	import aphdc_pkg::*;
;
	logic       sys_clk, sys_rst, ub_ad_oe_n, utx_enb_n, utx_soc, utx_clav;
	logic       ub_ale = 1'b0, ub_cs_n = 1'b1, ub_rd_n = 1'b1, ub_wr_n = 1'b1;
	logic [7:0] tb_ad = 8'h00, ub_ad_in, ub_ad_out, utx_data, urx_data;
	logic [7:0] line_tx_data, line_rx_data = 8'h00, rd;
	logic       urx_enb_n, urx_parity, urx_soc, urx_oe_n, urx_clav;
	logic       line_tx_soc, line_tx_valid, line_tx_ready = 1'b1, stall = 0;
	logic       line_rx_soc = 1'b0, line_rx_valid = 1'b0, line_rx_mark = 1'b0;
	logic       receive_timing_marker, rx_hec_error, tx_led_n, rx_led_n;
	logic [7:0] txq [$];
	int         fail_count, checks_done, cyc, hec_cnt, mk_cnt, n0, soc_cnt;
	assign ub_ad_in = ub_ad_oe_n ? tb_ad : ub_ad_out;

	aphdc_top u_aphdc_top (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.ub_ale(ub_ale), .ub_cs_n(ub_cs_n), .ub_rd_n(ub_rd_n),
		.ub_wr_n(ub_wr_n), .ub_ad_in(ub_ad_in), .ub_ad_out(ub_ad_out),
		.ub_ad_oe_n(ub_ad_oe_n), .utx_enb_n(utx_enb_n), .utx_data(utx_data),
		.utx_soc(utx_soc), .utx_clav(utx_clav), .urx_enb_n(urx_enb_n),
		.urx_data(urx_data), .urx_parity(urx_parity), .urx_soc(urx_soc),
		.urx_oe_n(urx_oe_n), .urx_clav(urx_clav),
		.line_tx_data(line_tx_data), .line_tx_soc(line_tx_soc),
		.line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready),
		.line_rx_data(line_rx_data), .line_rx_soc(line_rx_soc),
		.line_rx_valid(line_rx_valid), .line_rx_mark(line_rx_mark),
		.receive_timing_marker(receive_timing_marker),
		.rx_hec_error(rx_hec_error),
		.transmit_activity_indicator_n(tx_led_n),
		.receive_activity_indicator_n(rx_led_n));
	aphdc_atm_model u_aphdc_atm_model (.sys_clk(sys_clk),
		.utx_enb_n(utx_enb_n), .utx_data(utx_data), .utx_soc(utx_soc),
		.utx_clav(utx_clav), .urx_enb_n(urx_enb_n), .urx_data(urx_data),
		.urx_soc(urx_soc), .urx_oe_n(urx_oe_n), .urx_clav(urx_clav));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Line stalls every other cycle while stall is set
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (line_tx_valid === 1'b1 && line_tx_ready === 1'b1)
			txq.push_back(line_tx_data);
		if (line_tx_valid === 1'b1 && line_tx_ready === 1'b1 &&
			line_tx_soc === 1'b1)
			soc_cnt <= soc_cnt + 1;
		if (rx_hec_error === 1'b1)
			hec_cnt <= hec_cnt + 1;
		if (receive_timing_marker === 1'b1)
			mk_cnt <= mk_cnt + 1;
		line_tx_ready <= #1 stall ? ~line_tx_ready : 1'b1;
		if (cyc > 40000) begin
			fail_count++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Strobes are held four cycles so the two-flop synchronisers see them
	task automatic addr(input logic [7:0] a);
		ub_cs_n = 1'b0;
		ub_ale  = 1'b1;
		tb_ad   = a;
		step(4);
		ub_ale = 1'b0;
		step(4);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr(a);
		tb_ad   = d;
		ub_wr_n = 1'b0;
		step(4);
		ub_wr_n = 1'b1;
		step(4);
		ub_cs_n = 1'b1;
		tb_ad   = ~d;
		step(4);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] exp);
		int w;
		addr(a);
		ub_rd_n = 1'b0;
		for (w = 0; w < 20 && ub_ad_oe_n !== 1'b0; w++)
			step(1);
		if (w == 20)
			fail_count++;
		step(2);
		rd      = ub_ad_out;
		ub_rd_n = 1'b1;
		ub_cs_n = 1'b1;
		check(rd & m, exp);
		step(5);
	endtask
	function automatic logic [7:0] hec4(input logic [7:0] b);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 4; i++) begin
			c = c ^ (b + i[7:0]);
			for (int j = 0; j < 8; j++)
				c = c[7] ? {c[6:0], 1'b0} ^ HEC_POLY : {c[6:0], 1'b0};
		end
		return c ^ HEC_COSET;
	endfunction
	task automatic lcell(input logic [7:0] b, input logic bad);
		for (int i = 0; i < 53; i++) begin
			line_rx_valid = 1'b1;
			line_rx_soc   = (i == 0);
			line_rx_data  = (i == 4) ? hec4(b) ^ {7'h00, bad} : b + i[7:0];
			step(1);
		end
		line_rx_valid = 1'b0;
		line_rx_soc   = 1'b0;
		line_rx_data  = ~line_rx_data;
		step(1);
	endtask
	task automatic rcell(input logic [7:0] b, input logic early, more);
		step(1);
		for (int w = 0; w < 200 && urx_clav !== 1'b1; w++)
			step(1);
		u_aphdc_atm_model.read_cell();
		check(urx_parity, ~^(b + 8'h34));
		check(u_aphdc_atm_model.got[0], b);
		check(u_aphdc_atm_model.soc0, 8'h01);
		check(u_aphdc_atm_model.got[52], b + 8'h34);
		check(u_aphdc_atm_model.cav[47], 8'h01);
		check(u_aphdc_atm_model.cav[48], !early || more);
		check(u_aphdc_atm_model.cav[52], more);
	endtask
	task automatic tcell(input logic [7:0] b, input logic [2:0] f);
		txq.delete();
		n0 = soc_cnt;
		u_aphdc_atm_model.send_cell(b);
		for (int w = 0; w < 300 && txq.size() < 53; w++)
			step(1);
		check(8'(soc_cnt - n0), 8'h01);
		check(txq.size(), 8'h35);
		check(txq[0], b);
		check(txq[4], (f[2] ? b + 8'h04 : hec4(b)) ^ f[1]);
		check(txq[52], (b + 8'h34) ^ f[0]);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		step(10);
		sys_rst = 1'b0;
		step(2);
		rchk(REG_DIAG_OFS, 8'hff, DIAG_RST);
		rchk(REG_HECC_OFS, 8'hff, 8'h07);
		rchk(8'h05, 8'hff, 8'h00);
		wr(REG_HECC_OFS, 8'hff);
		rchk(REG_HECC_OFS, 8'hff, 8'h7f);
		wr(REG_HECC_OFS, 8'h00);
		wr(REG_DIAG_OFS, 8'h6f);
		rchk(REG_DIAG_OFS, 8'hff, 8'h6f);
		wr(REG_DIAG_OFS, 8'h00);
		$display("registers done");
		stall = 1'b1;
		tcell(8'h10, 3'h0);
		stall = 1'b0;
		rchk(REG_HECC_OFS, 8'h06, 8'h04);
		wr(REG_DIAG_OFS, 8'h0c);
		tcell(8'h20, 3'h3);
		wr(REG_HECC_OFS, 8'h20);
		wr(REG_DIAG_OFS, 8'h04);
		tcell(8'h30, 3'h6);
		wr(REG_HECC_OFS, 8'h00);
		wr(REG_DIAG_OFS, 8'h80);
		check(utx_clav, 8'h00);
		wr(REG_DIAG_OFS, 8'h00);
		check(utx_clav, 8'h01);
		$display("transmit done");
		lcell(8'h40, 1'b1);
		rcell(8'h40, 1'b0, 1'b0);
		check(hec_cnt, 8'h01);
		rchk(REG_HECC_OFS, 8'h01, 8'h00);
		wr(REG_HECC_OFS, 8'h40);
		lcell(8'h50, 1'b1);
		rcell(8'h50, 1'b0, 1'b0);
		check(hec_cnt, 8'h01);
		wr(REG_HECC_OFS, 8'h00);
		wr(REG_DIAG_OFS, 8'h40);
		lcell(8'h60, 1'b0);
		lcell(8'h70, 1'b0);
		rcell(8'h60, 1'b1, 1'b1);
		rcell(8'h70, 1'b1, 1'b0);
		check(urx_oe_n, 8'h00);
		wr(REG_DIAG_OFS, 8'h20);
		check(urx_oe_n, 8'h01);
		lcell(8'h80, 1'b0);
		rcell(8'h80, 1'b0, 1'b0);
		check(u_aphdc_atm_model.oe0, 8'h00);
		$display("receive done");
		lcell(8'h90, 1'b0);
		lcell(8'ha0, 1'b0);
		wr(REG_DIAG_OFS, 8'h10);
		rchk(REG_DIAG_OFS, 8'hff, 8'h00);
		check(urx_clav, 8'h00);
		lcell(8'hb0, 1'b0);
		rcell(8'hb0, 1'b0, 1'b0);
		for (int c = 0; c < 4; c++) begin
			wr(REG_HECC_OFS, c[1:0] << HECC_REFW_LSB);
			n0           = mk_cnt;
			line_rx_mark = 1'b1;
			step(1);
			line_rx_mark = 1'b0;
			step(20);
			check(mk_cnt - n0, 8'h01 << c);
		end
		$display("flush and marker done");
		wr(REG_DIAG_OFS, {6'h00, LOOP_PHY});
		txq.delete();
		u_aphdc_atm_model.send_cell(8'hc0);
		step(5);
		check(txq.size(), 8'h00);
		rcell(8'hc0, 1'b0, 1'b0);
		for (int lp = 2; lp < 4; lp++) begin
			wr(REG_DIAG_OFS, lp[7:0]);
			txq.delete();
			lcell(8'hd0, 1'b0);
			step(10);
			check(txq.size(), 8'h35);
			check(txq[0], 8'hd0);
			wr(REG_DIAG_OFS, 8'h10);
		end
		$display("loopback done");
		finish_test();
	end
endmodule // aphdc_top_tb
`default_nettype wire
